/* iop_power_mgmt.sv */
`timescale 1ns/100ps
`include "iop_cfg.svh"

// Function
// - timer unit bit picks second or minute
// - gate bit passes management interrupt to pins
// - bit zero switches serial IRQ pull-up
// - reserved control bits always read zero
// - idle flag set when device timer expires
// - flags self-managed; write one clears
// - printer sleeps only without any activity
// - floppy sleeps only without activity or motor
// - serial sleeps only when quiet and stable
// - wake sets flag and reloads idle timer
// - printer wakes on access, irq, pins
// - floppy wakes on access, irq, motor
// - serial wakes on access, irq, start, modem
// - irq level register shows live irq pins
// - edge printer irq level pulses briefly
// - upper status bits read as zero
// - idle timer counts down; zero disables
// - device manages power only when both enabled
// - interrupt is OR of enabled irq levels
// - global standby timer sleeps whole chip
module iop_power_mgmt
	import iop_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `IOP_CLK_HZ
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             ext_mode,
	input  wire iop_bus_req_t     bus_req,
	input  wire iop_dev_act_t     dev_act,
	input  wire iop_pm_cfg_t      pm_cfg,
	input  wire logic [3:0][7:0]  idle_count,
	output logic      [7:0]       rdata_q,
	output logic                  rdata_valid_q,
	output logic                  smi_n_q,
	output logic                  serial_irq_out_q,
	output logic                  serial_irq_oe_n_q,
	output logic                  serial_irq_pullup_on_q,
	output logic      [3:0]       dev_sleep_q,
	output logic                  chip_sleep_q
);

	// Prescaler width; a one-cycle tick still needs one bit of counter.
	localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	// The prescaler cannot produce a tick shorter than one cycle, so a zero divider is refused here.
	if (TICK_CYCLES < 1) begin : g_bad_tick
		$error("TICK_CYCLES must be at least one");
	end

	// The minute divider counts seconds in six bits; a longer minute would wrap before its tick.
	if (`IOP_SEC_PER_MIN > 64 || `IOP_SEC_PER_MIN < 1) begin : g_bad_minute
		$error("seconds per minute must lie between 1 and 64");
	end

	// Decodes one configuration index into its read value.
	// Unmapped, test and reserved slots all read as zero, so a stray index never shows stale state.
	function automatic logic [7:0] reg_read(
		input logic [7:0] idx,
		input logic [7:0] ctrl,
		input logic [3:0] idle,
		input logic [3:0] wake,
		input logic [3:0] lvl
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			`IOP_IDX_PWR_CTRL:   v = ctrl & `IOP_PWR_CTRL_MASK;
			`IOP_IDX_IDLE_FLAGS: v = {4'h0, idle};
			`IOP_IDX_WAKE_FLAGS: v = {4'h0, wake};
			`IOP_IDX_IRQ_LEVELS: v = {4'h0, lvl};
			default:             v = 8'h00;
		endcase
		return v;
	endfunction : reg_read

	// Host-visible registers behind the data port.
	logic [7:0]           index_q;
	logic [7:0]           pwr_ctrl_q;
	logic [3:0]           idle_flags_q;
	logic [3:0]           wake_flags_q;

	// Shared time base; every idle timer and the standby timer step on the same tick.
	logic [TW-1:0]        presc_q;
	logic                 sec_tick_q;
	logic [5:0]           sec_cnt_q;
	logic                 min_tick_q;

	// Last samples of the inputs whose changes count as activity.
	logic [4:0]           pins_prev_q;
	logic [3:0]           motor_prev_q;
	logic [7:0]           modem_prev_q;

	// Per-device power machines and the chip-wide standby machine.
	logic [3:0][7:0]      idle_cnt_q;
	iop_pm_state_t        dev_st_q [4];
	iop_pm_state_t        chip_st_q;
	logic [7:0]           standby_cnt_q;
	logic                 standby_run_q;

	// Decoded strobes, causes and transitions of the current cycle.
	logic                 data_wr;
	logic                 tick;
	logic [3:0]           activity;
	logic [3:0]           busy;
	logic [3:0]           dev_en;
	logic [3:0]           go_wake;
	logic [3:0]           go_sleep;
	logic [3:0]           all_sleep;

	// Management interrupt before and after its gate.
	logic                 smi_raw;
	logic                 smi_gated;

	// A data port write only counts in extended mode; outside it the port pair is inert.
	assign data_wr = bus_req.wr & bus_req.data_sel & ext_mode;

	// Index port write selects the register reached through the data port.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			index_q <= 8'h00;
		end else if (bus_req.wr && !bus_req.data_sel && ext_mode) begin
			index_q <= bus_req.wdata;
		end
	end

	// Power control register; the test and reserved slots take no write at all.
	// Reserved positions are masked on the way in, so they cannot be set even for one cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pwr_ctrl_q <= `IOP_PWR_CTRL_RST;
		end else if (data_wr && index_q == `IOP_IDX_PWR_CTRL) begin
			pwr_ctrl_q <= bus_req.wdata & `IOP_PWR_CTRL_MASK;
		end
	end

	// Read answer appears one cycle after the read strobe; outside extended mode nothing answers.
	// The index port reads back the current index, which lets a host confirm its selection.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q       <= 8'h00;
			rdata_valid_q <= 1'b0;
		end else begin
			rdata_valid_q <= bus_req.rd & ext_mode;
			if (bus_req.rd && ext_mode) begin
				rdata_q <= bus_req.data_sel ?
					reg_read(index_q, pwr_ctrl_q, idle_flags_q, wake_flags_q, dev_act.irq) : index_q;
			end
		end
	end

	// Second prescaler and minute divider; the unit bit then picks which tick drives every timer.
	// The seconds count runs on in either unit, so a switch to minutes may give a short first minute.
	// That costs at most one minute of idle time and saves a restart of the divider.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc_q    <= '0;
			sec_tick_q <= 1'b0;
			sec_cnt_q  <= 6'h00;
			min_tick_q <= 1'b0;
		end else begin
			sec_tick_q <= (presc_q == TW'(TICK_CYCLES - 1));
			presc_q    <= (presc_q == TW'(TICK_CYCLES - 1)) ? '0 : presc_q + 1'b1;
			min_tick_q <= 1'b0;
			if (sec_tick_q) begin
				if (sec_cnt_q == 6'(`IOP_SEC_PER_MIN - 1)) begin
					sec_cnt_q  <= 6'h00;
					min_tick_q <= 1'b1;
				end else begin
					sec_cnt_q <= sec_cnt_q + 6'h01;
				end
			end
		end
	end

	// The unit bit is read live, so a change takes effect at the next tick and the current counts are kept.
	assign tick = pwr_ctrl_q[`IOP_BIT_TIMER_UNIT] ? min_tick_q : sec_tick_q;

	// Previous samples of the external inputs whose transitions count as activity.
	// They reset to zero, so inputs that idle high see one change after reset; that only restarts a count.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pins_prev_q  <= 5'h00;
			motor_prev_q <= 4'h0;
			modem_prev_q <= 8'h00;
		end else begin
			pins_prev_q  <= dev_act.printer_pins;
			motor_prev_q <= dev_act.motor_enable;
			modem_prev_q <= dev_act.modem_inputs;
		end
	end

	// Wake causes per device; busy levels keep a device from counting down at all.
	always_comb begin
		activity = dev_act.access | dev_act.irq;
		busy     = 4'h0;

		// Printer: DMA acknowledge and any change on its status pins.
		activity[`IOP_DEV_PRINTER] = activity[`IOP_DEV_PRINTER] | dev_act.dack[1]
			| (|(dev_act.printer_pins ^ pins_prev_q));

		// Floppy: DMA acknowledge and a motor bit turning on; a running motor holds it awake.
		activity[`IOP_DEV_FLOPPY] = activity[`IOP_DEV_FLOPPY] | dev_act.dack[0]
			| (|(dev_act.motor_enable & ~motor_prev_q));
		busy[`IOP_DEV_FLOPPY] = |dev_act.motor_enable;

		// Serial ports: start bits and modem changes wake; a busy receiver or transmitter holds.
		activity[`IOP_DEV_SERIAL_A] = activity[`IOP_DEV_SERIAL_A] | dev_act.rx_start[1]
			| dev_act.tx_start[1] | (|(dev_act.modem_inputs[7:4] ^ modem_prev_q[7:4]));
		activity[`IOP_DEV_SERIAL_B] = activity[`IOP_DEV_SERIAL_B] | dev_act.rx_start[0]
			| dev_act.tx_start[0] | (|(dev_act.modem_inputs[3:0] ^ modem_prev_q[3:0]));
		busy[`IOP_DEV_SERIAL_A] = ~dev_act.rx_wait_start[1] | ~dev_act.tx_shift_empty[1];
		busy[`IOP_DEV_SERIAL_B] = ~dev_act.rx_wait_start[0] | ~dev_act.tx_shift_empty[0];
	end

	// Both enables must be set; either one low keeps the device in its working state.
	assign dev_en = pm_cfg.dev_pm_enable & {4{pm_cfg.chip_power_mgmt_enable}};

	// One power-down machine per device, identical apart from its causes.
	// The count reloads on every cause, not only on a wake, so a busy device that never slept
	// still restarts its idle period each time it is used.
	for (genvar d = 0; d < 4; d++) begin : g_dev
		logic awake_cause;

		// Anything that wakes a device also keeps a working one from counting down.
		assign awake_cause = activity[d] | busy[d];

		// Decides the transitions of this device in the current cycle.
		always_comb begin
			go_wake[d]  = dev_en[d] && awake_cause && dev_st_q[d] == IOP_SLEEPING;
			go_sleep[d] = dev_en[d] && !awake_cause && dev_st_q[d] == IOP_WORKING
				&& idle_count[d] != 8'h00 && tick && idle_cnt_q[d] <= 8'h01;
		end

		// A zero count stops the countdown, so a working device stays working; a cause still wakes a sleeping one; disabling returns to working.
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				dev_st_q[d]   <= IOP_WORKING;
				idle_cnt_q[d] <= 8'h00;
			end else if (!dev_en[d]) begin
				dev_st_q[d]   <= IOP_WORKING;
				idle_cnt_q[d] <= idle_count[d];
			end else if (awake_cause) begin
				dev_st_q[d]   <= IOP_WORKING;
				idle_cnt_q[d] <= idle_count[d];
			end else if (go_sleep[d]) begin
				dev_st_q[d]   <= IOP_SLEEPING;
				idle_cnt_q[d] <= 8'h00;
			end else if (tick && dev_st_q[d] == IOP_WORKING && idle_count[d] != 8'h00) begin
				idle_cnt_q[d] <= idle_cnt_q[d] - 8'h01;
			end
		end

		// Raw state feeds the standby machine; the pin copy follows one cycle later.
		assign all_sleep[d] = dev_st_q[d] == IOP_SLEEPING;
	end

	// Idle flags: hardware set beats both its own clear and a host write of one.
	// Letting the set win keeps a host clear from hiding an expiry that lands in the same cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idle_flags_q <= `IOP_FLAGS_RST;
		end else begin
			idle_flags_q <= go_sleep | (idle_flags_q & ~go_wake
				& ~((data_wr && index_q == `IOP_IDX_IDLE_FLAGS) ? bus_req.wdata[3:0] : 4'h0));
		end
	end

	// Wake flags clear on their own when the device falls asleep again.
	// A host write of one clears a bit as well; the set still wins on a tie.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_flags_q <= `IOP_FLAGS_RST;
		end else begin
			wake_flags_q <= go_wake | (wake_flags_q & ~go_sleep
				& ~((data_wr && index_q == `IOP_IDX_WAKE_FLAGS) ? bus_req.wdata[3:0] : 4'h0));
		end
	end

	// Global standby: loads when every device sleeps, any wake abandons it.
	// The count is taken once per entry into all-asleep, so a new count only affects the next entry.
	// A zero count stops the standby countdown; a sleeping chip still wakes once any device wakes.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			chip_st_q     <= IOP_WORKING;
			standby_cnt_q <= 8'h00;
			standby_run_q <= 1'b0;
		end else if (!pm_cfg.chip_power_mgmt_enable || !(&all_sleep) || (|go_wake)) begin
			chip_st_q     <= IOP_WORKING;
			standby_run_q <= 1'b0;
		end else if (pm_cfg.standby_count == 8'h00) begin
			standby_run_q <= 1'b0;
		end else if (!standby_run_q) begin
			if (chip_st_q == IOP_WORKING) begin
				standby_cnt_q <= pm_cfg.standby_count;
				standby_run_q <= 1'b1;
			end
		end else if (tick) begin
			if (standby_cnt_q <= 8'h01) begin
				chip_st_q     <= IOP_SLEEPING;
				standby_run_q <= 1'b0;
			end else begin
				standby_cnt_q <= standby_cnt_q - 8'h01;
			end
		end
	end

	// Management interrupt reads the live levels, so a pulsed printer request only lasts its pulse.
	// A host that must know whether such a pulse happened has to ask the printer itself.
	assign smi_raw   = |(pm_cfg.irq_smi_enable & dev_act.irq);
	assign smi_gated = smi_raw & pwr_ctrl_q[`IOP_BIT_GATE] & pm_cfg.chip_power_mgmt_enable;

	// Pin outputs are registered to keep glitches off the board.
	// The serial line is only ever pulled low here; its high level comes from the pull-up or other drivers.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			smi_n_q                <= 1'b1;
			serial_irq_out_q       <= 1'b1;
			serial_irq_oe_n_q      <= 1'b1;
			serial_irq_pullup_on_q <= 1'b0;
			dev_sleep_q            <= 4'h0;
			chip_sleep_q           <= 1'b0;
		end else begin
			smi_n_q                <= ~smi_gated;
			serial_irq_out_q       <= 1'b0;
			serial_irq_oe_n_q      <= ~(smi_gated & pm_cfg.serial_irq_mode);
			serial_irq_pullup_on_q <= pwr_ctrl_q[`IOP_BIT_PULLUP] & pm_cfg.serial_irq_mode;
			dev_sleep_q            <= all_sleep;
			chip_sleep_q           <= chip_st_q == IOP_SLEEPING;
		end
	end

endmodule : iop_power_mgmt

/* iop_cfg.svh */
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// Configuration register indices reached through the data port.
`define IOP_IDX_PWR_CTRL    8'h3a
`define IOP_IDX_TEST        8'h3b
`define IOP_IDX_IDLE_FLAGS  8'h40
`define IOP_IDX_WAKE_FLAGS  8'h41
`define IOP_IDX_IRQ_LEVELS  8'h42
`define IOP_IDX_RSVD_A      8'h43
`define IOP_IDX_RSVD_B      8'h44

// Field positions of the power control register.
`define IOP_BIT_TIMER_UNIT  5
`define IOP_BIT_GATE        1
`define IOP_BIT_PULLUP      0

// Writable bits of the power control register; all others read as zero.
`define IOP_PWR_CTRL_MASK   8'h23
`define IOP_PWR_CTRL_RST    8'h00
`define IOP_FLAGS_RST       4'h0

// Device positions inside the four-bit status fields.
`define IOP_DEV_PRINTER     2'd3
`define IOP_DEV_FLOPPY      2'd2
`define IOP_DEV_SERIAL_A    2'd1
`define IOP_DEV_SERIAL_B    2'd0

// Time base: one second at 125 MHz, and seconds per minute.
`define IOP_CLK_HZ          125000000
`define IOP_SEC_PER_MIN     60

`endif

/* iop_pkg.sv */
package iop_pkg;

	// Power state of one device machine and of the whole chip.
	typedef enum logic {
		IOP_WORKING,
		IOP_SLEEPING
	} iop_pm_state_t;

	// Host access to the index/data port pair.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       data_sel;
		logic [7:0] wdata;
	} iop_bus_req_t;

	// Activity seen from the four devices, bit order printer, floppy, serial A, serial B.
	typedef struct packed {
		logic [3:0] access;
		logic [3:0] irq;
		logic [1:0] dack;
		logic [4:0] printer_pins;
		logic [3:0] motor_enable;
		logic [1:0] rx_wait_start;
		logic [1:0] tx_shift_empty;
		logic [1:0] rx_start;
		logic [1:0] tx_start;
		logic [7:0] modem_inputs;
	} iop_dev_act_t;

	// Settings held by neighbouring configuration registers.
	typedef struct packed {
		logic       chip_power_mgmt_enable;
		logic [3:0] dev_pm_enable;
		logic [3:0] irq_smi_enable;
		logic [7:0] standby_count;
		logic       serial_irq_mode;
	} iop_pm_cfg_t;

endpackage : iop_pkg

/* iop_power_mgmt_props.sv */
`timescale 1ns/100ps
// Port-side checker; shadows the index and control registers from the host strobes.
module iop_power_mgmt_props
	import iop_pkg::*;
(
	input wire logic            clk,
	input wire logic            nrst,
	input wire logic            ext_mode,
	input wire iop_bus_req_t    bus_req,
	input wire iop_dev_act_t    dev_act,
	input wire iop_pm_cfg_t     pm_cfg,
	input wire logic [3:0][7:0] idle_count,
	input wire logic [7:0]      rdata_q,
	input wire logic            rdata_valid_q,
	input wire logic            smi_n_q,
	input wire logic            serial_irq_oe_n_q,
	input wire logic [3:0]      dev_sleep_q,
	input wire logic            chip_sleep_q
);
	logic [7:0] idx_q;
	logic [7:0] ctrl_q;
	logic [1:0] up_q;
	logic       smi_cause;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	// The shadow lets the gate be predicted without looking inside the block.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			idx_q  <= 8'h00;
			ctrl_q <= 8'h00;
		end else if (bus_req.wr && ext_mode && !bus_req.data_sel) begin
			idx_q <= bus_req.wdata;
		end else if (bus_req.wr && ext_mode && idx_q == 8'h3a) begin
			ctrl_q <= bus_req.wdata & 8'h23;
		end
	end

	// Outputs only follow their inputs from the second edge after reset, so checks wait for three.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end

	assign smi_cause = |(pm_cfg.irq_smi_enable & dev_act.irq) && ctrl_q[1] && pm_cfg.chip_power_mgmt_enable;

	sequence rd_of(logic [7:0] i);
		rdata_valid_q && $past(bus_req.data_sel) && $past(idx_q) == i;
	endsequence
	sequence prt_wakes;
		dev_sleep_q[3] && (dev_act.access[3] || $changed(dev_act.printer_pins)) && idle_count[3] != 8'h00;
	endsequence

	a_read_answer: assert property (up_q == 2'h3 |-> rdata_valid_q == $past(bus_req.rd && ext_mode))
		else $error("read answer pulse wrong");
	a_ctrl_readback: assert property (rd_of(8'h3a) |-> rdata_q == $past(ctrl_q))
		else $error("control register readback wrong");
	a_flags_upper: assert property (rd_of(8'h40) or rd_of(8'h41) |-> rdata_q[7:4] == 4'h0)
		else $error("status upper bits not zero");
	a_irq_live: assert property (rd_of(8'h42) |-> rdata_q == {4'h0, $past(dev_act.irq)})
		else $error("irq level read wrong");
	a_smi_gate: assert property (up_q == 2'h3 |-> smi_n_q == !$past(smi_cause))
		else $error("management interrupt pin wrong");
	a_serial_drive: assert property (up_q == 2'h3 |->
		serial_irq_oe_n_q == !($past(smi_cause) && $past(pm_cfg.serial_irq_mode)))
		else $error("serial irq drive wrong");
	a_pm_disabled: assert property (!pm_cfg.chip_power_mgmt_enable |-> ##2 dev_sleep_q == 4'h0)
		else $error("device asleep while disabled");
	a_prt_wake: assert property (prt_wakes |-> ##[1:2] !dev_sleep_q[3])
		else $error("printer did not wake");
	a_motor_awake: assert property (dev_act.motor_enable != 4'h0 && idle_count[2] != 8'h00
		|-> ##[1:2] !dev_sleep_q[2])
		else $error("floppy asleep with motor on");
	a_serial_busy: assert property (!dev_act.rx_wait_start[1] |-> ##2 !dev_sleep_q[1])
		else $error("serial slept while receiving");
	a_standby_all: assert property (dev_sleep_q != 4'hf ##1 dev_sleep_q != 4'hf |-> !chip_sleep_q)
		else $error("chip asleep with a device awake");
endmodule : iop_power_mgmt_props

/* iop_host_model.sv */
`timescale 1ns/100ps
// Host on the index/data port pair; every access names the register first.
module iop_host_model
	import iop_pkg::*;
(
	input  wire logic       clk,
	input  wire logic [7:0] rdata_q,
	input  wire logic       rdata_valid_q,
	output iop_bus_req_t    bus_req,
	output logic            ext_mode
);
	// Extended function mode is entered once and kept; the test register is never written.
	initial begin
		bus_req  = '0;
		ext_mode = 1'b1;
	end

	// One strobe held for one edge; released data turns over so stale values are not mistaken.
	task automatic strobe(input logic w, input logic sel, input logic [7:0] d);
		@(posedge clk);
		#1;
		bus_req = '{wr: w, rd: !w, data_sel: sel, wdata: d};
		@(posedge clk);
		#1;
		bus_req = '{wr: 1'b0, rd: 1'b0, data_sel: sel, wdata: ~d};
	endtask : strobe

	task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
		strobe(1'b1, 1'b0, idx);
		strobe(1'b1, 1'b1, d);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
		strobe(1'b1, 1'b0, idx);
		strobe(1'b0, 1'b1, 8'h00);
		d = rdata_valid_q ? rdata_q : 8'hxx;
	endtask : rd_reg
endmodule : iop_host_model

/* iop_power_mgmt_bench.sv */
`timescale 1ns/100ps
module iop_power_mgmt_bench
	import iop_pkg::*;
;
	logic            clk = 1'b0;
	logic            nrst = 1'b0;
	logic            ext_mode;
	iop_bus_req_t    bus_req;
	iop_dev_act_t    act;
	iop_pm_cfg_t     cfg;
	logic [3:0][7:0] cnt;
	logic [7:0]      rdata_q;
	logic [7:0]      rd;
	logic            rdata_valid_q, smi_n_q, out_q, oe_n_q, pull_q, chip_sleep_q;
	logic [3:0]      dev_sleep_q;
	logic [7:0]      rst_idx [6] = '{8'h3a, 8'h3b, 8'h40, 8'h41, 8'h43, 8'h44};
	int              mismatches = 0;
	int              n_compared = 0;

	always #4 clk = ~clk;

	// A short tick keeps second and minute counts within a few thousand cycles.
	iop_power_mgmt #(.TICK_CYCLES(10)) i_dut (.clk, .nrst, .ext_mode, .bus_req, .dev_act(act), .pm_cfg(cfg),
		.idle_count(cnt), .rdata_q, .rdata_valid_q, .smi_n_q, .serial_irq_out_q(out_q), .serial_irq_oe_n_q(oe_n_q),
		.serial_irq_pullup_on_q(pull_q), .dev_sleep_q, .chip_sleep_q);
	iop_host_model i_host (.clk, .rdata_q, .rdata_valid_q, .bus_req, .ext_mode);

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic expect_reg(input logic [7:0] idx, input logic [7:0] exp);
		i_host.rd_reg(idx, rd);
		check($sformatf("register %h", idx), exp, rd);
	endtask : expect_reg

	task automatic cycles(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cycles

	task automatic wait_sleep(input logic [3:0] exp, input int lim);
		for (int i = 0; i < lim && dev_sleep_q !== exp; i++) cycles(1);
		check("dev_sleep_q", {4'h0, exp}, {4'h0, dev_sleep_q});
	endtask : wait_sleep

	task close_out;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out

	// The tests need under 3000 cycles; this limit leaves four times that.
	initial begin
		#100000;
		mismatches++;
		close_out();
	end

	// Register map, management interrupt path, then the four power-down machines.
	initial begin
		act = '0;
		act.rx_wait_start = 2'h3;
		act.tx_shift_empty = 2'h3;
		cfg = '0;
		cfg.serial_irq_mode = 1'b1;
		cnt = {4{8'h02}};
		cycles(6);
		nrst = 1'b1;
		check("smi_n_q", 8'h01, {7'h0, smi_n_q});
		foreach (rst_idx[i]) expect_reg(rst_idx[i], 8'h00);
		i_host.wr_reg(8'h3a, 8'hff);
		expect_reg(8'h3a, 8'h23);
		check("pullup", 8'h01, {7'h0, pull_q});
		cfg.serial_irq_mode = 1'b0;
		cycles(2);
		check("pullup", 8'h00, {7'h0, pull_q});
		cfg.serial_irq_mode = 1'b1;
		i_host.wr_reg(8'h3a, 8'h02);
		expect_reg(8'h3a, 8'h02);
		check("pullup", 8'h00, {7'h0, pull_q});
		cfg.chip_power_mgmt_enable = 1'b1;
		cfg.irq_smi_enable = 4'h4;
		act.irq = 4'h3;
		i_host.wr_reg(8'h42, 8'hff);
		expect_reg(8'h42, 8'h03);
		check("smi_n_q", 8'h01, {7'h0, smi_n_q});
		act.irq = 4'h4;
		cycles(2);
		check("smi_n_q", 8'h00, {7'h0, smi_n_q});
		check("oe_n_q", 8'h00, {7'h0, oe_n_q});
		check("out_q", 8'h00, {7'h0, out_q});
		i_host.wr_reg(8'h3a, 8'h00);
		cycles(2);
		check("smi_n_q", 8'h01, {7'h0, smi_n_q});
		act.irq = 4'h8;
		cycles(1);
		act.irq = 4'h0;
		expect_reg(8'h42, 8'h00);
		cfg.dev_pm_enable = 4'hf;
		cfg.standby_count = 8'h01;
		wait_sleep(4'hf, 40);
		expect_reg(8'h40, 8'h0f);
		i_host.wr_reg(8'h40, 8'h05);
		expect_reg(8'h40, 8'h0a);
		i_host.wr_reg(8'h40, 8'h00);
		expect_reg(8'h40, 8'h0a);
		cycles(12);
		check("chip_sleep_q", 8'h01, {7'h0, chip_sleep_q});
		// Each pass wakes one device by a different cause; the woken bit equals the pass number.
		for (int k = 0; k < 4; k++) begin
			wait_sleep(4'hf, 40);
			case (k)
				0: act.access[0] = 1'b1;
				1: begin
					act.modem_inputs[4] = ~act.modem_inputs[4];
					act.rx_wait_start[1] = 1'b0;
				end
				2: act.motor_enable[1] = 1'b1;
				default: act.printer_pins[2] = ~act.printer_pins[2];
			endcase
			cycles(1);
			act.access = '0;
			act.motor_enable = '0;
			act.rx_wait_start = 2'h3;
			cycles(2);
			check("dev_sleep_q", 8'h0f & ~(8'h01 << k), {4'h0, dev_sleep_q});
			check("chip_sleep_q", 8'h00, {7'h0, chip_sleep_q});
			expect_reg(8'h41, 8'h01 << k);
		end
		cfg.chip_power_mgmt_enable = 1'b0;
		cycles(2);
		check("dev_sleep_q", 8'h00, {4'h0, dev_sleep_q});
		i_host.wr_reg(8'h3a, 8'h20);
		cfg.chip_power_mgmt_enable = 1'b1;
		cycles(500);
		check("dev_sleep_q", 8'h00, {4'h0, dev_sleep_q});
		wait_sleep(4'hf, 800);
		close_out();
	end
endmodule : iop_power_mgmt_bench

bind iop_power_mgmt iop_power_mgmt_props i_props (.clk, .nrst, .ext_mode, .bus_req, .dev_act, .pm_cfg, .idle_count,
	.rdata_q, .rdata_valid_q, .smi_n_q, .serial_irq_oe_n_q, .dev_sleep_q, .chip_sleep_q);
